// ---- rtl/ers_device.sv ----
// Device end: reset sources, ready flag, EEPROM probe and link hold
//
// Design decisions made here: the address map and the plain strobed port.
`include "ers_consts.svh"
`default_nettype none
module ers_device #(
   // Divide first so the default counts stay inside a 32-bit int
   parameter int PWRUP_CYC = `ERS_PWRUP_NS / 1000 * `ERS_CLK_MHZ, // reset period
   parameter int WAKE_CYC = `ERS_WAKE_NS / 1000 * `ERS_CLK_MHZ, // wake time
   parameter int PHYRST_CYC = `ERS_PHYRST_NS / 1000 * `ERS_CLK_MHZ // PHY reset
) (
   input wire logic clk, // clock
   input wire logic sys_rst, // power-on reset
   ers_if.dev bus, // host side pins
   input wire logic [3:0] strapPins, // configuration straps
   input wire logic eepromPresent, // EEPROM answers the probe
   input wire logic linkUp, // PHY link status
   input wire logic txPending, // queued transmit data waiting
   output logic txGo, // transmit may proceed
   output logic macRst, // MAC and fifo_mac_link_logic reset
   output logic phyRst, // PHY reset
   output logic clkGenRst, // clock generator reset
   output logic [3:0] strapLatch_q, // latched straps
   output logic macAddrReload // pulse: reload station address
);
   localparam int WHOLE_SOFT_RESET_BIT_CYC = `ERS_WHOLE_SOFT_RESET_BIT_NS * `ERS_CLK_MHZ / 1000;
   localparam logic [31:0] PROBE_CYC = 32'(`ERS_PROBE_CYC);
   ////////////////////////////////////////////////////////////////////
   // Pin synchroniser
   logic pinMeta_q;
   logic pinSync_q;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pinMeta_q <= 1'b0;
         pinSync_q <= 1'b0;
      end
      else
      begin
         pinMeta_q <= bus.rstLowPin;
         pinSync_q <= pinMeta_q;
      end
   end
   logic pinRst;
   assign pinRst = ~pinSync_q;
   ////////////////////////////////////////////////////////////////////
   // Timers
   logic holdLoad, holdBusy, holdDone;
   logic srstLoad, srstBusy, srstDone;
   logic phyLoad, phyBusy, phyDone;
   logic [31:0] holdCnt;
   ers_timer #(.WIDTH(32)) uHold (.clk(clk), .sys_rst(sys_rst), .load(holdLoad),
      .count(holdCnt), .busy(holdBusy), .done(holdDone));
   ers_timer #(.WIDTH(32)) uSrst (.clk(clk), .sys_rst(sys_rst), .load(srstLoad),
      .count(32'(WHOLE_SOFT_RESET_BIT_CYC)), .busy(srstBusy), .done(srstDone));
   ers_timer #(.WIDTH(32)) uPhy (.clk(clk), .sys_rst(sys_rst), .load(phyLoad),
      .count(32'(PHYRST_CYC)), .busy(phyBusy), .done(phyDone));
   ////////////////////////////////////////////////////////////////////
   // Sequencer
   ers_pkg::dev_state_type state_q, state_d;
   logic ready_q, ready_d;
   logic e2pBusy_q, e2pBusy_d;
   logic reloadNow;
   logic [1:0] pmMode_q, pmMode_d;
   logic phyViaCtl_q, phyViaCtl_d;
   logic pinPrev_q;
   logic wrHw, wrPmt, wrTest, wrPhy0;
   assign wrHw = bus.wrEn && bus.addr == `ERS_ADR_HWCFG;
   assign wrPmt = bus.wrEn && bus.addr == `ERS_ADR_PMT;
   assign wrTest = bus.wrEn && bus.addr == `ERS_ADR_TEST;
   assign wrPhy0 = bus.wrEn && bus.addr == `ERS_ADR_PHY0;
   logic startSoft, startPhy, startPhy0, probeStart;
   always_comb
   begin
      state_d = state_q;
      ready_d = ready_q;
      e2pBusy_d = e2pBusy_q;
      reloadNow = 1'b0;
      pmMode_d = pmMode_q;
      phyViaCtl_d = phyViaCtl_q;
      holdLoad = 1'b0;
      holdCnt = 32'(PWRUP_CYC);
      probeStart = 1'b0;
      // Sleeping device ignores every write but the wake write
      startSoft = wrHw && bus.wrData[`ERS_WHOLE_SOFT_RESET_BIT_BIT] && ready_q && !srstBusy;
      startPhy = wrPmt && bus.wrData[`ERS_PHYRST_BIT] && ready_q;
      startPhy0 = wrPhy0 && bus.wrData[`ERS_PHY0RST_BIT] && ready_q;
      if (startPhy0)
         phyViaCtl_d = 1'b1;
      else if (phyDone)
         phyViaCtl_d = 1'b0;
      if (pinRst)
      begin
         state_d = ers_pkg::ERS_HOLD;
         ready_d = 1'b0;
         holdLoad = 1'b1;
         pmMode_d = 2'h0;
      end
      else
         case (state_q)
            ers_pkg::ERS_HOLD:
               if (holdDone)
               begin
                  state_d = ers_pkg::ERS_RUN;
                  ready_d = 1'b1;
                  probeStart = 1'b1;
               end
            ers_pkg::ERS_RUN:
            begin
               if (srstDone)
                  probeStart = 1'b1;
               if (wrPmt && ready_q && (bus.wrData[`ERS_PMMODE_LO+1 -: 2] == `ERS_MODE_SLEEP1
                  || bus.wrData[`ERS_PMMODE_LO+1 -: 2] == `ERS_MODE_SLEEP2))
               begin
                  pmMode_d = bus.wrData[`ERS_PMMODE_LO+1 -: 2];
                  ready_d = 1'b0;
                  state_d = ers_pkg::ERS_SLEEP;
               end
            end
            // Waking is no reset: the MAC stays out of reset and no probe follows
            ers_pkg::ERS_SLEEP:
               if (wrTest)
               begin
                  pmMode_d = 2'h0;
                  holdLoad = 1'b1;
                  holdCnt = 32'(WAKE_CYC);
               end
               else if (holdDone)
               begin
                  state_d = ers_pkg::ERS_RUN;
                  ready_d = 1'b1;
               end
            ers_pkg::ERS_PROBE: state_d = ers_pkg::ERS_PROBE;
            default: state_d = ers_pkg::ERS_HOLD;
         endcase
      if (probeStart)
      begin
         e2pBusy_d = 1'b1;
         state_d = ers_pkg::ERS_PROBE;
      end
      else if (state_q == ers_pkg::ERS_PROBE && !pinRst && !holdBusy)
      begin
         e2pBusy_d = 1'b0;
         // Only an EEPROM that answered can supply a station address
         reloadNow = eepromPresent;
         state_d = ers_pkg::ERS_RUN;
      end
      if (state_q == ers_pkg::ERS_PROBE && probeStart == 1'b0 && !pinRst)
      begin
         holdLoad = 1'b0;
      end
      if (probeStart)
      begin
         holdLoad = 1'b1;
         holdCnt = PROBE_CYC;
      end
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q <= ers_pkg::ERS_HOLD;
         ready_q <= 1'b0;
         e2pBusy_q <= 1'b0;
         pmMode_q <= 2'h0;
         phyViaCtl_q <= 1'b0;
         pinPrev_q <= 1'b0;
         strapLatch_q <= 4'h0;
      end
      else
      begin
         state_q <= state_d;
         ready_q <= ready_d;
         e2pBusy_q <= e2pBusy_d;
         pmMode_q <= pmMode_d;
         phyViaCtl_q <= phyViaCtl_d;
         pinPrev_q <= pinRst;
         if (pinRst)
            strapLatch_q <= strapPins;
      end
   end
   assign srstLoad = startSoft;
   // A pin reset restarts the PHY interval too
   assign phyLoad = startPhy || startPhy0 || (pinPrev_q && !pinRst);
   // Soft reset leaves clock, PHY, straps and exempt state alone
   assign macRst = pinRst || srstBusy || state_q == ers_pkg::ERS_HOLD;
   assign phyRst = pinRst || phyBusy;
   assign clkGenRst = pinRst;
   assign macAddrReload = reloadNow;
   assign txGo = txPending && linkUp && !phyRst;
   ////////////////////////////////////////////////////////////////////
   // Read port
   logic [31:0] rd_d;
   always_comb
   begin
      rd_d = 32'h0;
      case (bus.addr)
         `ERS_ADR_HWCFG: rd_d[`ERS_WHOLE_SOFT_RESET_BIT_BIT] = srstBusy;
         `ERS_ADR_PMT:
         begin
            rd_d[`ERS_READY_BIT] = ready_q;
            rd_d[`ERS_PHYRST_BIT] = phyBusy && !phyViaCtl_q;
            rd_d[`ERS_PMMODE_LO+1 -: 2] = pmMode_q;
         end
         `ERS_ADR_E2P: rd_d[`ERS_E2PBUSY_BIT] = e2pBusy_q;
         `ERS_ADR_PHY0: rd_d[`ERS_PHY0RST_BIT] = phyBusy && phyViaCtl_q;
         `ERS_ADR_PHY1: rd_d[`ERS_LINK_BIT] = linkUp && !phyBusy;
         `ERS_ADR_MODE: rd_d[3:0] = strapLatch_q;
         default: rd_d = 32'h0;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst || !bus.rdEn)
         bus.rdData <= 32'h0;
      else
         bus.rdData <= rd_d;
   end
endmodule
`default_nettype wire

// ---- rtl/ers_consts.svh ----
// Constants for the Ethernet reset sequencer
`ifndef ERS_CONSTS_SVH
`define ERS_CONSTS_SVH
`define ERS_CLK_MHZ 250
`define ERS_WHOLE_SOFT_RESET_BIT_NS 2000
`define ERS_PHYRST_NS 100000
`define ERS_WAKE_NS 1000000
`define ERS_PWRUP_NS 22000000
`define ERS_PINLOW_NS 30000000
`define ERS_TIMEOUT_NS 100000000
`define ERS_PROBE_CYC 16
// Register map of the device, word addresses
`define ERS_ADR_HWCFG 8'h74
`define ERS_ADR_PMT 8'h84
`define ERS_ADR_E2P 8'hb4
`define ERS_ADR_TEST 8'h64
`define ERS_ADR_PHY0 8'hf0
`define ERS_ADR_PHY1 8'hf1
`define ERS_ADR_MODE 8'hf2
// Field positions
`define ERS_WHOLE_SOFT_RESET_BIT_BIT 0
`define ERS_PHYRST_BIT 10
`define ERS_READY_BIT 0
`define ERS_PMMODE_LO 12
`define ERS_E2PBUSY_BIT 31
`define ERS_PHY0RST_BIT 15
`define ERS_LINK_BIT 2
`define ERS_MODE_SLEEP1 2'h1
`define ERS_MODE_SLEEP2 2'h2
// Controller registers reached by software
`define ERS_C_CMD 4'h0
`define ERS_C_STAT 4'h1
`define ERS_C_CMD_PWRON 0
`define ERS_C_CMD_SOFT 1
`define ERS_C_CMD_PHY 2
`define ERS_C_CMD_PHY0 3
`define ERS_C_CMD_WAKE 4
`define ERS_C_CMD_SLEEP 5
`endif

// ---- rtl/ers_pkg.sv ----
// Types shared by both ends of the reset sequencer
`default_nettype none
package ers_pkg;
   typedef enum logic [3:0] {
      ERS_RUN = 4'h1,
      ERS_HOLD = 4'h2,
      ERS_PROBE = 4'h4,
      ERS_SLEEP = 4'h8
   } dev_state_type;
   typedef enum logic [4:0] {
      ERS_H_IDLE = 5'h01,
      ERS_H_WRITE = 5'h02,
      ERS_H_POLL = 5'h04,
      ERS_H_WAIT = 5'h08,
      ERS_H_ERR = 5'h10
   } host_state_type;
endpackage
`default_nettype wire

// ---- rtl/ers_if.sv ----
// Interface joining host and device of the reset sequencer
`default_nettype none
interface ers_if;
   logic rstLowPin;
   logic [7:0] addr;
   logic [31:0] wrData;
   logic wrEn;
   logic rdEn;
   logic [31:0] rdData;
   modport dev (input rstLowPin, input addr, input wrData, input wrEn, input rdEn,
      output rdData);
   modport host (output rstLowPin, output addr, output wrData, output wrEn,
      output rdEn, input rdData);
endinterface
`default_nettype wire

// ---- rtl/ers_timer.sv ----
// Down counter that flags the end of a timed interval
`default_nettype none
module ers_timer #(
   parameter int WIDTH = 32
) (
   input wire logic clk, // clock
   input wire logic sys_rst, // sync reset
   input wire logic load, // start a new interval
   input wire logic [WIDTH-1:0] count, // cycles of the interval
   output logic busy, // interval running
   output logic done // one-cycle pulse at the end
);
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;
   logic done_d;
   always_comb
   begin
      cnt_d = cnt_q;
      done_d = 1'b0;
      if (load)
         cnt_d = count;
      else if (cnt_q != '0)
      begin
         cnt_d = cnt_q - 1'b1;
         done_d = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
      end
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cnt_q <= '0;
         done <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         done <= done_d;
      end
   end
   assign busy = (cnt_q != '0);
endmodule
`default_nettype wire

// ---- rtl/ers_host.sv ----
// Host end: sequences resets for software and polls the device
`include "ers_consts.svh"
`default_nettype none
module ers_host #(
   parameter int PIN_CYC = `ERS_PINLOW_NS / 1000 * `ERS_CLK_MHZ, // pin low time
   parameter int TIMEOUT_CYC = `ERS_TIMEOUT_NS / 1000 * `ERS_CLK_MHZ // poll limit
) (
   input wire logic clk, // clock
   input wire logic sys_rst, // sync reset
   ers_if.host bus, // device pins
   input wire logic [3:0] swAddr, // software address
   input wire logic [31:0] swWrData, // software write data
   input wire logic swWr, // software write strobe
   input wire logic swRd, // software read strobe
   output logic [31:0] swRdData_q // software read data
);
   ers_pkg::host_state_type state_q, state_d;
   logic [31:0] cnt_q, cnt_d;
   logic [2:0] op_q, op_d;
   logic err_q, err_d;
   logic pinLow_q, pinLow_d;
   logic polled_q, polled_d;
   logic rdLate_q;
   logic wrEn_d, rdEn_d;
   logic [7:0] addr_d;
   logic [31:0] wr_d;
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      op_d = op_q;
      err_d = err_q;
      pinLow_d = pinLow_q;
      polled_d = 1'b0;
      wrEn_d = 1'b0;
      rdEn_d = 1'b0;
      addr_d = `ERS_ADR_PMT;
      wr_d = 32'h0;
      case (state_q)
         ers_pkg::ERS_H_IDLE:
            if (swWr && swAddr == `ERS_C_CMD)
            begin
               err_d = 1'b0;
               cnt_d = 32'h0;
               if (swWrData[`ERS_C_CMD_PWRON])
               begin
                  pinLow_d = 1'b1;
                  state_d = ers_pkg::ERS_H_WAIT;
               end
               else
               begin
                  op_d = swWrData[`ERS_C_CMD_WAKE] ? 3'h4 :
                     swWrData[`ERS_C_CMD_SLEEP] ? 3'h5 :
                     swWrData[`ERS_C_CMD_PHY0] ? 3'h3 :
                     swWrData[`ERS_C_CMD_PHY] ? 3'h2 : 3'h1;
                  // Everything but the wake write waits for ready first
                  state_d = swWrData[`ERS_C_CMD_WAKE] ? ers_pkg::ERS_H_WRITE :
                     ers_pkg::ERS_H_POLL;
               end
            end
         ers_pkg::ERS_H_WAIT:
         begin
            cnt_d = cnt_q + 32'h1;
            // Ready is sampled while the pin is low too; those answers are not used
            rdEn_d = &cnt_q[3:0];
            if (cnt_q == 32'(PIN_CYC))
            begin
               pinLow_d = 1'b0;
               cnt_d = 32'h0;
               op_d = 3'h0;
               state_d = ers_pkg::ERS_H_POLL;
            end
         end
         ers_pkg::ERS_H_POLL:
         begin
            rdEn_d = !polled_q;
            polled_d = !polled_q;
            cnt_d = cnt_q + 32'h1;
            if (op_q == 3'h6)
               addr_d = `ERS_ADR_HWCFG;
            // Read data stand only in the cycle after the strobe; ops 6 and 7 wait for a fall
            if (rdLate_q && bus.rdData[op_q == 3'h6 ? `ERS_WHOLE_SOFT_RESET_BIT_BIT : `ERS_READY_BIT]
               != (op_q[2:1] == 2'h3))
               state_d = op_q == 3'h0 || op_q == 3'h4 || op_q[2:1] == 2'h3 ?
                  ers_pkg::ERS_H_IDLE : ers_pkg::ERS_H_WRITE;
            else if (cnt_q >= 32'(TIMEOUT_CYC))
               state_d = ers_pkg::ERS_H_ERR;
         end
         ers_pkg::ERS_H_WRITE:
         begin
            wrEn_d = 1'b1;
            cnt_d = 32'h0;
            case (op_q)
               3'h1:
               begin
                  addr_d = `ERS_ADR_HWCFG;
                  wr_d[`ERS_WHOLE_SOFT_RESET_BIT_BIT] = 1'b1;
               end
               3'h2: wr_d[`ERS_PHYRST_BIT] = 1'b1;
               3'h3:
               begin
                  addr_d = `ERS_ADR_PHY0;
                  wr_d[`ERS_PHY0RST_BIT] = 1'b1;
               end
               3'h4: addr_d = `ERS_ADR_TEST;
               default: wr_d[`ERS_PMMODE_LO+1 -: 2] = `ERS_MODE_SLEEP1;
            endcase
            // Soft reset and sleep entry are confirmed by reading back
            op_d = op_q == 3'h1 ? 3'h6 : op_q == 3'h5 ? 3'h7 : op_q;
            state_d = op_q == 3'h1 || op_q >= 3'h4 ? ers_pkg::ERS_H_POLL : ers_pkg::ERS_H_IDLE;
         end
         ers_pkg::ERS_H_ERR:
         begin
            err_d = 1'b1;
            state_d = ers_pkg::ERS_H_IDLE;
         end
         default: state_d = ers_pkg::ERS_H_IDLE;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q <= ers_pkg::ERS_H_IDLE;
         cnt_q <= 32'h0;
         op_q <= 3'h0;
         err_q <= 1'b0;
         pinLow_q <= 1'b0;
         polled_q <= 1'b0;
         rdLate_q <= 1'b0;
         bus.wrEn <= 1'b0;
         bus.rdEn <= 1'b0;
         bus.addr <= 8'h0;
         bus.wrData <= 32'h0;
         swRdData_q <= 32'h0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         op_q <= op_d;
         err_q <= err_d;
         pinLow_q <= pinLow_d;
         polled_q <= polled_d;
         rdLate_q <= bus.rdEn;
         bus.wrEn <= wrEn_d;
         bus.rdEn <= rdEn_d;
         bus.addr <= addr_d;
         bus.wrData <= wr_d;
         swRdData_q <= swRd && swAddr == `ERS_C_STAT ?
            {29'h0, err_q, state_q != ers_pkg::ERS_H_IDLE, pinLow_q} : 32'h0;
      end
   end
   assign bus.rstLowPin = ~pinLow_q;
endmodule
`default_nettype wire

// ---- tb/ers_assertions.sv ----
// Checker for the bus that joins host and device of the reset sequencer
`include "ers_consts.svh"
`default_nettype none
module ers_assertions #(
   parameter int PIN_CYC = 20,
   parameter int PWRUP_CYC = 50,
   parameter int WAKE_CYC = 50,
   parameter int PHYRST_CYC = 50
) (
   input wire logic clk, // clock
   input wire logic sys_rst, // sync reset
   input wire logic rstLowPin, // reset pin
   input wire logic [7:0] addr, // word address
   input wire logic [31:0] wrData, // write data
   input wire logic wrEn, // write strobe
   input wire logic rdEn, // read strobe
   input wire logic [31:0] rdData // read data
);
   localparam int WHOLE_SOFT_RESET_BIT_CYC = `ERS_WHOLE_SOFT_RESET_BIT_NS * `ERS_CLK_MHZ / 1000;
   logic [15:0] lowCnt_q, relCnt_q, srCnt_q, phCnt_q, wkCnt_q;
   logic relOk_q, rdyOk_q, srOk_q, phOk_q, slp_q, wkOk_q;
   logic pmtRd, wrPmt, wrTest, wrSoft, sleepWr;
   assign pmtRd = rdEn && addr == `ERS_ADR_PMT;
   assign wrPmt = wrEn && addr == `ERS_ADR_PMT;
   assign wrTest = wrEn && addr == `ERS_ADR_TEST;
   assign wrSoft = wrEn && addr == `ERS_ADR_HWCFG && wrData[`ERS_WHOLE_SOFT_RESET_BIT_BIT];
   assign sleepWr = wrPmt && (wrData[13:12] == `ERS_MODE_SLEEP1
      || wrData[13:12] == `ERS_MODE_SLEEP2);
   // Counters saturate so a long quiet spell never wraps into a false window
   function automatic logic [15:0] sat(input logic [15:0] v);
      return (&v) ? v : v + 16'h1;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         {lowCnt_q, relCnt_q, srCnt_q, phCnt_q, wkCnt_q} <= '0;
         {relOk_q, rdyOk_q, srOk_q, phOk_q, slp_q, wkOk_q} <= '0;
      end
      else
      begin
         lowCnt_q <= rstLowPin ? 16'h0 : sat(lowCnt_q);
         relCnt_q <= rstLowPin ? sat(relCnt_q) : 16'h0;
         relOk_q <= relOk_q || !rstLowPin;
         srCnt_q <= wrSoft ? 16'h0 : sat(srCnt_q);
         srOk_q <= rstLowPin && (srOk_q || wrSoft);
         phCnt_q <= (wrPmt && wrData[`ERS_PHYRST_BIT]) ? 16'h0 : sat(phCnt_q);
         phOk_q <= rstLowPin && (phOk_q || (wrPmt && wrData[`ERS_PHYRST_BIT]));
         slp_q <= rstLowPin && !wrTest && (slp_q || sleepWr);
         wkCnt_q <= wrTest ? 16'h0 : sat(wkCnt_q);
         wkOk_q <= rstLowPin && !sleepWr && (wkOk_q || (wrTest && slp_q));
         rdyOk_q <= rstLowPin && !sleepWr && (rdyOk_q || ($past(pmtRd) && rdData[0]));
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_pmt_rd;
      rdEn && addr == `ERS_ADR_PMT;
   endsequence
   sequence s_pin_held;
      !rstLowPin && !$past(rstLowPin) && !$past(rstLowPin, 2) && !$past(rstLowPin, 3);
   endsequence
   property p_rd_idle;
      !rdEn |=> rdData == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   property p_ready_pin;
      s_pin_held ##0 s_pmt_rd |=> !rdData[`ERS_READY_BIT];
   endproperty
   a_ready_pin: assert property (p_ready_pin) else $error("ready during pin");
   property p_hold;
      relOk_q && rstLowPin && relCnt_q < PWRUP_CYC ##0 s_pmt_rd |=> !rdData[0];
   endproperty
   a_hold: assert property (p_hold) else $error("ready too early");
   property p_wr_ready;
      wrEn && addr != `ERS_ADR_TEST |-> rdyOk_q;
   endproperty
   a_wr_ready: assert property (p_wr_ready) else $error("write before ready");
   // One cycle of slack for how the host counts its own low time
   property p_pin_width;
      $rose(rstLowPin) |-> lowCnt_q >= PIN_CYC - 1;
   endproperty
   a_pin_width: assert property (p_pin_width) else $error("pin pulse short");
   property p_whole_soft_reset_bit_clr;
      srOk_q ##0 (rdEn && addr == `ERS_ADR_HWCFG)
         |=> !rdData[`ERS_WHOLE_SOFT_RESET_BIT_BIT] || srCnt_q <= WHOLE_SOFT_RESET_BIT_CYC + 16;
   endproperty
   a_whole_soft_reset_bit_clr: assert property (p_whole_soft_reset_bit_clr) else $error("soft bit stuck");
   property p_phy_clr;
      phOk_q ##0 s_pmt_rd |=> !rdData[`ERS_PHYRST_BIT] || phCnt_q <= PHYRST_CYC + 16;
   endproperty
   a_phy_clr: assert property (p_phy_clr) else $error("phy bit stuck");
   property p_sleep;
      slp_q ##0 s_pmt_rd |=> !rdData[`ERS_READY_BIT];
   endproperty
   a_sleep: assert property (p_sleep) else $error("ready while asleep");
   property p_wake;
      wkOk_q ##0 s_pmt_rd |=> rdData[`ERS_READY_BIT] || wkCnt_q <= WAKE_CYC + 16;
   endproperty
   a_wake: assert property (p_wake) else $error("wake too slow");
   // The host never touches the EEPROM command register, so it cannot race the probe
   property p_e2p_hands_off;
      wrEn |-> addr != `ERS_ADR_E2P;
   endproperty
   a_e2p_hands_off: assert property (p_e2p_hands_off) else $error("eeprom written");
endmodule
`default_nettype wire

// ---- tb/ethernet_reset_sequencer_test.sv ----
// Bench: host and device ends joined, software port and device pins driven
`include "ers_consts.svh"
`default_nettype none
module ethernet_reset_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   // Short counts keep the run small; the checker gets the same values
   localparam int PIN = 20;
   localparam int HOLD = 50;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] swAddr = 4'h0, strapPins = 4'h0, strapExp = 4'h0, seen = 4'h0;
   logic [31:0] swWrData = 32'h0, rd;
   logic swWr = 1'b0, swRd = 1'b0, eepromPresent = 1'b0, linkUp = 1'b0, txPending = 1'b0;
   logic clrSeen = 1'b0;
   logic [31:0] swRdData_q;
   logic txGo, macRst, phyRst, clkGenRst, macAddrReload;
   logic [3:0] strapLatch_q;
   int bad_count = 0;
   int checks_done = 0;
   ers_if rbus ();
   ers_host #(.PIN_CYC(PIN), .TIMEOUT_CYC(2000)) u_ers_host (.clk(clk), .sys_rst(sys_rst),
      .bus(rbus), .swAddr(swAddr), .swWrData(swWrData), .swWr(swWr), .swRd(swRd),
      .swRdData_q(swRdData_q));
   ers_device #(.PWRUP_CYC(HOLD), .WAKE_CYC(HOLD), .PHYRST_CYC(HOLD)) u_ers_device (
      .clk(clk), .sys_rst(sys_rst), .bus(rbus), .strapPins(strapPins),
      .eepromPresent(eepromPresent), .linkUp(linkUp), .txPending(txPending), .txGo(txGo),
      .macRst(macRst), .phyRst(phyRst), .clkGenRst(clkGenRst),
      .strapLatch_q(strapLatch_q), .macAddrReload(macAddrReload));
   ers_assertions #(.PIN_CYC(PIN), .PWRUP_CYC(HOLD), .WAKE_CYC(HOLD), .PHYRST_CYC(HOLD))
      u_ers_assertions (.clk(clk), .sys_rst(sys_rst), .rstLowPin(rbus.rstLowPin),
      .addr(rbus.addr), .wrData(rbus.wrData), .wrEn(rbus.wrEn), .rdEn(rbus.rdEn),
      .rdData(rbus.rdData));
   always #2 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      swAddr <= a;
      swWrData <= d;
      swWr <= 1'b1;
      @(posedge clk);
      swWr <= 1'b0;
   endtask
   task automatic sw_read(input logic [3:0] a);
      @(posedge clk);
      swAddr <= a;
      swRd <= 1'b1;
      @(posedge clk);
      swRd <= 1'b0;
      #1 rd = swRdData_q;
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do
      begin
         sw_read(`ERS_C_STAT);
         n++;
      end while (rd[1] !== 1'b0 && n < 3000);
      check("hostError", rd[2:1], 2'h0);
   endtask
   // Bits: clock generator, MAC, PHY, station address reload (only if an EEPROM answers)
   function automatic logic [3:0] effect(input int c, input logic e);
      case (c)
         `ERS_C_CMD_PWRON: return {3'h7, e};
         `ERS_C_CMD_SOFT: return {3'h2, e};
         `ERS_C_CMD_PHY, `ERS_C_CMD_PHY0: return 4'h2;
         default: return 4'h0;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      seen <= clrSeen ? 4'h0 : seen | {clkGenRst === 1'b1, macRst === 1'b1, phyRst === 1'b1,
         macAddrReload === 1'b1};
      linkUp <= 1'($urandom);
      txPending <= 1'($urandom);
   end
   always @(negedge clk)
      if (phyRst === 1'b1)
         check("txHeld", txGo, 1'b0);
   initial
   begin
      int cmds[8] = '{`ERS_C_CMD_PWRON, `ERS_C_CMD_PHY, `ERS_C_CMD_SOFT, `ERS_C_CMD_SOFT,
         `ERS_C_CMD_PHY0, `ERS_C_CMD_SLEEP, `ERS_C_CMD_WAKE, `ERS_C_CMD_PWRON};
      void'($urandom(32'h55ba));
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (cmds[i])
      begin
         @(posedge clk);
         strapPins <= 4'($urandom);
         eepromPresent <= 1'($urandom);
         clrSeen <= 1'b1;
         sw_write(`ERS_C_CMD, 32'h1 << cmds[i]);
         clrSeen <= 1'b0;
         wait_idle();
         // Soft reset lasts about 500 cycles; let every reset run out
         repeat (600) @(posedge clk);
         #1;
         if (cmds[i] == `ERS_C_CMD_PWRON)
            strapExp = strapPins;
         check("resetSeen", seen, effect(cmds[i], eepromPresent));
         check("resetsOff", {clkGenRst, macRst, phyRst}, 3'h0);
         check("straps", strapLatch_q, strapExp);
      end
      repeat (20)
      begin
         @(negedge clk);
         check("txGo", txGo, linkUp & txPending);
      end
      stop_test();
   end
   initial
   begin
      #(4 * 80000);
      bad_count++;
      stop_test();
   end
endmodule
`default_nettype wire
